/* shared/tsf_regs.svh */
`ifndef TSF_REGS_SVH
`define TSF_REGS_SVH

// ----------------------------------------
// Register offsets (plain port, word index)
// ----------------------------------------
`define TSF_ADDR_CTRL 4'h0
`define TSF_ADDR_STATUS 4'h1
`define TSF_ADDR_IRQ_STAT 4'h2
`define TSF_ADDR_IRQ_EN 4'h3
`define TSF_ADDR_IRQ_CLR 4'h4
`define TSF_ADDR_TAPS 4'h5
`define TSF_ADDR_RESULT 4'h6
`define TSF_ADDR_COEF0 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSF_CTRL_INIT_BIT 0
`define TSF_ST_CFG_OK_BIT 0
`define TSF_ST_BAD_CFG_BIT 1
`define TSF_ST_SETTLED_BIT 2
`define TSF_IRQ_RESULT_BIT 0
`define TSF_IRQ_BADCFG_BIT 1
`define TSF_IRQ_SETTLED_BIT 2

// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define TSF_TAPS_MIN 2
`define TSF_TAPS_MAX 9
`define TSF_FRAC_BITS 14
`define TSF_COEF_MAX 16'sh4000
`define TSF_COEF_MIN 16'shc000
`define TSF_SUM_MAX 32'sh00008000
`define TSF_SUM_MIN 32'shffff8000
`define TSF_RESULT_MAX 16'hffff
`define TSF_TAPS_RST 4'h5
`define TSF_COEF_RST 16'h0ccc

`endif

/* shared/tsf_pkg.sv */
package tsf_pkg;
  typedef enum logic [1:0] {
    TSF_IDLE,
    TSF_CHECK,
    TSF_MAC,
    TSF_DONE
  } tsf_state_t;
endpackage

/* design/tsf_fir.sv */
// The address map and the strobed register port were left to the implementer.
`include "tsf_regs.svh"

module tsf_fir #(
  parameter int TAPS_MAX = `TSF_TAPS_MAX
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Sample stream
  input wire logic sample_valid,
  input wire logic [15:0] sample_data,
  output logic sample_ready,
  // Result stream
  output logic result_valid,
  output logic [15:0] result_data,
  output logic result_settled,
  // Status and interrupt
  output logic status_ok,
  output logic status_bad_config,
  output logic irq
);

  // Only the nine-deep line is served; coefficient 8 has no bus address and keeps its reset value
  if (TAPS_MAX != `TSF_TAPS_MAX)
  begin : g_bad_taps_max
    $error("tsf_fir: TAPS_MAX must be 9");
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] clamp_u16(input logic signed [31:0] acc);
    logic signed [31:0] sh;
    sh = acc >>> `TSF_FRAC_BITS;
    if (sh > 32'sh0000ffff)
      clamp_u16 = `TSF_RESULT_MAX;
    else if (sh < 32'sh0)
      clamp_u16 = 16'h0;
    else
      clamp_u16 = sh[15:0];
  endfunction
  function automatic logic coef_in_range(input logic signed [15:0] c);
    coef_in_range = (c <= `TSF_COEF_MAX) && (c >= `TSF_COEF_MIN);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  tsf_pkg::tsf_state_t state_ff;
  logic [3:0] taps_ff;
  logic signed [15:0] coef_ff [TAPS_MAX];
  logic [15:0] line_ff [TAPS_MAX];
  logic [3:0] idx_ff;
  logic signed [31:0] acc_ff;
  logic signed [31:0] csum_ff;
  logic cfg_bad_ff;
  logic cfg_ok_ff;
  logic [3:0] settle_ff;
  logic settled_ff;
  logic [15:0] result_ff;
  logic result_valid_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_en_ff;
  logic [15:0] rdata_ff;
  logic init_req;
  logic busy;
  logic cfg_fail;
  logic [2:0] irq_set;
  logic signed [31:0] prod;
  logic signed [31:0] acc_next;

  assign init_req = reg_wr && (reg_addr == `TSF_ADDR_CTRL) && reg_wdata[`TSF_CTRL_INIT_BIT];
  assign busy = (state_ff != tsf_pkg::TSF_IDLE);
  assign sample_ready = !busy && cfg_ok_ff;
  assign prod = 32'(coef_ff[idx_ff]) * 32'($signed({1'b0, line_ff[idx_ff]}));
  assign acc_next = acc_ff + prod;
  assign cfg_fail = cfg_bad_ff || (csum_ff > `TSF_SUM_MAX) || (csum_ff < `TSF_SUM_MIN);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_ff <= tsf_pkg::TSF_IDLE;
    else
    begin
      case (state_ff)
        tsf_pkg::TSF_IDLE:
        begin
          if (init_req)
            state_ff <= tsf_pkg::TSF_CHECK;
          else if (sample_valid && cfg_ok_ff)
            state_ff <= tsf_pkg::TSF_MAC;
        end
        tsf_pkg::TSF_CHECK:
        begin
          if (idx_ff == 4'(TAPS_MAX - 1))
            state_ff <= tsf_pkg::TSF_DONE;
        end
        tsf_pkg::TSF_MAC:
        begin
          if (idx_ff == taps_ff - 4'h1)
            state_ff <= tsf_pkg::TSF_DONE;
        end
        tsf_pkg::TSF_DONE:
          state_ff <= tsf_pkg::TSF_IDLE;
        default:
          state_ff <= tsf_pkg::TSF_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      idx_ff <= 4'h0;
    else if (state_ff == tsf_pkg::TSF_IDLE)
      idx_ff <= 4'h0;
    else if (state_ff != tsf_pkg::TSF_DONE)
      idx_ff <= idx_ff + 4'h1;
  end

  // ----------------------------------------
  // Configuration check
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      csum_ff <= 32'sh0;
      cfg_bad_ff <= 1'b0;
      cfg_ok_ff <= 1'b0;
    end
    else if (state_ff == tsf_pkg::TSF_IDLE && init_req)
    begin
      csum_ff <= 32'sh0;
      cfg_ok_ff <= 1'b0;
      cfg_bad_ff <= (taps_ff < 4'(`TSF_TAPS_MIN)) || (taps_ff > 4'(`TSF_TAPS_MAX));
    end
    else if (state_ff == tsf_pkg::TSF_CHECK)
    begin
      // Unused taps are skipped; only configured coefficients count
      if (idx_ff < taps_ff)
      begin
        csum_ff <= csum_ff + 32'(coef_ff[idx_ff]);
        if (!coef_in_range(coef_ff[idx_ff]))
          cfg_bad_ff <= 1'b1;
      end
    end
    else if (state_ff == tsf_pkg::TSF_DONE && !cfg_ok_ff && !result_valid_ff)
    begin
      if (cfg_fail)
        cfg_bad_ff <= 1'b1;
      else
        cfg_ok_ff <= 1'b1;
    end
    else if (reg_wr && reg_addr != `TSF_ADDR_CTRL && reg_addr != `TSF_ADDR_IRQ_EN
             && reg_addr != `TSF_ADDR_IRQ_CLR)
      cfg_ok_ff <= 1'b0; // Config edits need a fresh init
  end
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      taps_ff <= `TSF_TAPS_RST;
      for (int i = 0; i < TAPS_MAX; i++)
        coef_ff[i] <= `TSF_COEF_RST;
    end
    else if (reg_wr && !busy)
    begin
      if (reg_addr == `TSF_ADDR_TAPS)
        taps_ff <= reg_wdata[3:0];
      for (int i = 0; i < TAPS_MAX - 1; i++)
        if (reg_addr == 4'(`TSF_ADDR_COEF0 + i))
          coef_ff[i] <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Delay line and settling counter
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < TAPS_MAX; i++)
        line_ff[i] <= 16'h0;
    end
    else if (state_ff == tsf_pkg::TSF_CHECK)
    begin
      for (int i = 0; i < TAPS_MAX; i++)
        line_ff[i] <= 16'h0;
    end
    else if (state_ff == tsf_pkg::TSF_IDLE && !init_req && sample_valid && cfg_ok_ff)
    begin
      line_ff[0] <= sample_data;
      for (int i = 1; i < TAPS_MAX; i++)
        line_ff[i] <= line_ff[i - 1];
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      settle_ff <= 4'h0;
      settled_ff <= 1'b0;
    end
    else if (state_ff == tsf_pkg::TSF_CHECK)
    begin
      settle_ff <= 4'h0;
      settled_ff <= 1'b0;
    end
    // Counts one past the tap count so the settled event fires only once
    else if (state_ff == tsf_pkg::TSF_MAC && idx_ff == 4'h0 && settle_ff <= taps_ff)
    begin
      settle_ff <= settle_ff + 4'h1;
      if (settle_ff + 4'h1 >= taps_ff)
        settled_ff <= 1'b1;
    end
  end
  // ----------------------------------------
  // Multiply-accumulate and result
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      acc_ff <= 32'sh0;
    else if (state_ff == tsf_pkg::TSF_MAC)
      acc_ff <= acc_next;
    else
      acc_ff <= 32'sh0;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      result_ff <= 16'h0;
      result_valid_ff <= 1'b0;
    end
    else if (state_ff == tsf_pkg::TSF_MAC && idx_ff == taps_ff - 4'h1)
    begin
      result_ff <= clamp_u16(acc_next);
      result_valid_ff <= 1'b1;
    end
    else
      result_valid_ff <= 1'b0;
  end
  assign result_valid = result_valid_ff;
  assign result_data = result_ff;
  assign result_settled = settled_ff;
  assign status_ok = cfg_ok_ff;
  assign status_bad_config = cfg_bad_ff;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_set = {settled_ff && result_valid_ff && settle_ff == taps_ff,
                    state_ff == tsf_pkg::TSF_DONE && cfg_fail && !cfg_ok_ff && !result_valid_ff,
                    result_valid_ff};
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      irq_en_ff <= 3'h0;
    else if (reg_wr && reg_addr == `TSF_ADDR_IRQ_EN)
      irq_en_ff <= reg_wdata[2:0];
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      irq_stat_ff <= 3'h0;
    else if (reg_wr && reg_addr == `TSF_ADDR_IRQ_CLR)
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata[2:0]) | irq_set; // Set wins
    else
      irq_stat_ff <= irq_stat_ff | irq_set;
  end
  assign irq = |(irq_stat_ff & irq_en_ff);

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata_ff <= 16'h0;
    else if (reg_rd)
    begin
      rdata_ff <= 16'h0;
      case (reg_addr)
        `TSF_ADDR_STATUS: rdata_ff <= {13'h0, settled_ff, cfg_bad_ff, cfg_ok_ff};
        `TSF_ADDR_IRQ_STAT: rdata_ff <= {13'h0, irq_stat_ff};
        `TSF_ADDR_IRQ_EN: rdata_ff <= {13'h0, irq_en_ff};
        `TSF_ADDR_TAPS: rdata_ff <= {12'h0, taps_ff};
        `TSF_ADDR_RESULT: rdata_ff <= result_ff;
        default:
        begin
          for (int i = 0; i < TAPS_MAX - 1; i++)
            if (reg_addr == 4'(`TSF_ADDR_COEF0 + i))
              rdata_ff <= coef_ff[i];
        end
      endcase
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_step_start;
    state_ff == tsf_pkg::TSF_IDLE && !init_req && sample_valid && cfg_ok_ff;
  endsequence

  chk_step_result_valid: assert property (@(posedge mclk) disable iff (!rst_n)
    s_step_start |-> ##[2:10] result_valid)
    else $error("no result after sample");
  chk_result_clamp_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == tsf_pkg::TSF_MAC && idx_ff == taps_ff - 4'h1 && (acc_next >>> 14) > 32'sh0000ffff)
    |=> result_data == 16'hffff)
    else $error("high clamp missing");
  chk_result_clamp_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == tsf_pkg::TSF_MAC && idx_ff == taps_ff - 4'h1 && acc_next < 32'sh0)
    |=> result_data == 16'h0)
    else $error("low clamp missing");
  chk_newest_in_line: assert property (@(posedge mclk) disable iff (!rst_n)
    s_step_start |=> line_ff[0] == $past(sample_data))
    else $error("sample not shifted in");
  chk_init_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    state_ff == tsf_pkg::TSF_CHECK |=> settle_ff == 4'h0 && !settled_ff && line_ff[0] == 16'h0)
    else $error("init did not clear");
  chk_bad_taps: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == tsf_pkg::TSF_IDLE && init_req && (taps_ff < 4'h2 || taps_ff > 4'h9))
    |=> ##[1:12] (status_bad_config && !status_ok))
    else $error("bad taps accepted");
  chk_settle_early: assert property (@(posedge mclk) disable iff (!rst_n)
    result_valid && settle_ff < taps_ff |-> !result_settled)
    else $error("settled too early");
  chk_no_step_unconfig: assert property (@(posedge mclk) disable iff (!rst_n)
    state_ff == tsf_pkg::TSF_IDLE && !cfg_ok_ff |=> state_ff != tsf_pkg::TSF_MAC)
    else $error("step without good config");
endmodule

/* bench/tsf_src.sv */
module tsf_src (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic req,
  input wire logic [15:0] req_data,
  input wire logic [3:0] lag,
  // Sample stream toward the filter
  input wire logic sample_ready,
  output logic sample_valid,
  output logic [15:0] sample_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pend_ff;
  logic [3:0] wait_ff;
  logic [15:0] val_ff;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pend_ff <= 1'b0;
      wait_ff <= 4'h0;
      val_ff <= 16'h0000;
      sample_valid <= 1'b0;
      sample_data <= 16'h0000;
    end
    else if (sample_valid)
    begin
      // Data is not held past the strobe: show a changed value
      sample_valid <= 1'b0;
      sample_data <= ~sample_data;
    end
    else if (req)
    begin
      pend_ff <= 1'b1;
      val_ff <= req_data;
      wait_ff <= lag;
    end
    else if (pend_ff && wait_ff != 4'h0)
      wait_ff <= wait_ff - 4'h1;
    else if (pend_ff && sample_ready)
    begin
      sample_valid <= 1'b1;
      sample_data <= val_ff;
      pend_ff <= 1'b0;
    end
  end
endmodule

/* bench/tb_top.sv */
`include "tsf_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, rst_n, reg_wr, reg_rd, src_req;
  logic [3:0] reg_addr, src_lag;
  logic [15:0] reg_wdata, reg_rdata, src_data, v;
  logic sample_valid, sample_ready, result_valid, result_settled, status_ok, status_bad_config, irq;
  logic [15:0] sample_data, result_data, last_res;
  logic signed [15:0] cf [9];
  logic [15:0] hist [9];
  int err_total, samples_checked, taps, cnt;

  tsf_fir i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_ready(sample_ready), .result_valid(result_valid), .result_data(result_data),
    .result_settled(result_settled), .status_ok(status_ok), .status_bad_config(status_bad_config), .irq(irq));
  tsf_src i_src (.mclk(mclk), .rst_n(rst_n), .req(src_req), .req_data(src_data), .lag(src_lag),
    .sample_ready(sample_ready), .sample_valid(sample_valid), .sample_data(sample_data));

  always #4 mclk = ~mclk;

  task automatic test_done();
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic cfg_ok();
    int s;
    s = 0;
    if (taps < `TSF_TAPS_MIN || taps > `TSF_TAPS_MAX)
      return 1'b0;
    for (int i = 0; i < taps; i++)
    begin
      if (cf[i] > 16384 || cf[i] < -16384)
        return 1'b0;
      s += cf[i];
    end
    return s <= 32768 && s >= -32768;
  endfunction

  function automatic logic [15:0] exp_res();
    longint acc;
    acc = 0;
    for (int m = 0; m < taps; m++)
      acc += longint'(cf[m]) * longint'({1'b0, hist[m]});
    acc = acc >>> 14;
    return (acc > 65535) ? 16'hffff : (acc < 0) ? 16'h0000 : acc[15:0];
  endfunction

  // Program taps and coefficients 0..7, then run an init
  task automatic cfg();
    logic ok;
    ok = cfg_ok();
    wr(`TSF_ADDR_TAPS, 16'(taps));
    #1 chk_bit(status_ok, 1'b0, "ok after taps write");
    for (int i = 0; i < 8; i++)
      wr(`TSF_ADDR_COEF0 + 4'(i), cf[i]);
    wr(`TSF_ADDR_CTRL, 16'h0001);
    repeat (13) @(posedge mclk);
    #1 chk_bit(status_ok, ok, "status ok");
    chk_bit(status_bad_config, !ok, "status bad");
    for (int i = 0; i < 9; i++)
      hist[i] = 16'h0000;
    cnt = 0;
  endtask

  task automatic send(input logic [15:0] x, input logic [3:0] lg);
    int k;
    for (k = 8; k > 0; k--)
      hist[k] = hist[k - 1];
    hist[0] = x;
    cnt++;
    @(posedge mclk);
    src_req <= 1'b1;
    src_data <= x;
    src_lag <= lg;
    @(posedge mclk);
    src_req <= 1'b0;
    k = 0;
    do
    begin
      @(posedge mclk);
      #1 k++;
    end while (result_valid !== 1'b1 && k < 40);
    chk_bit(result_valid, 1'b1, "result strobe");
    last_res = exp_res();
    chk_word(result_data, last_res, "filter result");
    chk_bit(result_settled, cnt >= taps, "settled flag");
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk);
    err_total++;
    $display("mismatch %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    {mclk, rst_n, reg_wr, reg_rd, src_req} = '0;
    {reg_addr, src_lag, reg_wdata, src_data, last_res} = '0;
    err_total = 0;
    samples_checked = 0;
    taps = 5;
    for (int i = 0; i < 9; i++)
      cf[i] = 16'sh0ccc;
    void'($urandom(17));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk_bit(sample_ready, 1'b0, "ready before init");
    rd(`TSF_ADDR_TAPS, v);
    chk_word(v, `TSF_TAPS_RST, "taps reset");
    rd(`TSF_ADDR_COEF0, v);
    chk_word(v, `TSF_COEF_RST, "coef reset");
    rd(4'h7, v);
    chk_word(v, 16'h0000, "unmapped read");
    wr(`TSF_ADDR_IRQ_EN, 16'h0007);
    // One pass per limit: taps low, taps high, coef high, coef low, sum high; the sum is also over in the taps-high and coef-high passes
    for (int b = 0; b < 5; b++)
    begin
      taps = (b == 0) ? 1 : (b == 1) ? 10 : (b == 4) ? 3 : 2;
      cf[0] = (b == 2) ? 16'sh4001 : (b == 3) ? 16'shbfff : 16'sh4000;
      cf[1] = 16'sh4000;
      cf[2] = 16'sh0001;
      cfg();
      chk_bit(irq, 1'b1, "irq on bad config");
      rd(`TSF_ADDR_IRQ_STAT, v);
      chk_bit(v[`TSF_IRQ_BADCFG_BIT], 1'b1, "bad config event");
      wr(`TSF_ADDR_IRQ_CLR, 16'h0007);
      #1 chk_bit(irq, 1'b0, "irq after clear");
    end
    for (int t = 0; t < 7; t++)
    begin
      // Stimulus keeps coefficients and their sum legal
      taps = (t < 2) ? 2 : (t == 2) ? 9 : $urandom_range(2, 9);
      for (int i = 0; i < 8; i++)
        cf[i] = $urandom_range(0, 16'h1c00) - 16'h0e00;
      if (t < 2)
      begin
        cf[0] = (t == 0) ? 16'sh4000 : 16'shc000;
        cf[1] = (t == 0) ? 16'sh4000 : 16'sh0000;
      end
      cfg();
      for (int s = 0; s < taps + 2; s++)
        send((t == 0) ? 16'hffff : 16'($urandom), 4'($urandom_range(0, 3)));
    end
    rd(`TSF_ADDR_RESULT, v);
    chk_word(v, last_res, "result register");
    rd(`TSF_ADDR_IRQ_STAT, v);
    chk_word(v & 16'h0005, 16'h0005, "result and settled events");
    chk_bit(irq, 1'b1, "irq on result");
    wr(`TSF_ADDR_IRQ_EN, 16'h0000);
    #1 chk_bit(irq, 1'b0, "irq masked");
    wr(`TSF_ADDR_IRQ_CLR, 16'h0007);
    send(16'h1234, 4'h0);
    rd(`TSF_ADDR_IRQ_STAT, v);
    chk_bit(v[`TSF_IRQ_RESULT_BIT], 1'b1, "event while masked");
    chk_bit(irq, 1'b0, "irq stays masked");
    test_done();
  end
endmodule
